// file: spi_controller_config_core.sv
// Serial port controller: AHB-Lite registers, two frame FIFOs and the shift engine
`timescale 1ns/1ps
module spi_controller_config_core (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_b,
	input wire logic slave_select_pin_in,
	output logic slave_select_pin_out,
	output logic slave_select_pin_oe_b,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe_b,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe_b
);
	import spi_cfg_pkg::*;

	// ==========================================================
	// Helpers

	// Bit position of the idx-th bit on the wire
	function automatic logic [3:0] bit_pos(input logic [3:0] idx, input logic [3:0] last, input logic lsb);
		bit_pos = lsb ? idx : 4'(last - idx);
	endfunction

	// ==========================================================
	// Declarations

	// Configuration
	logic port_enable_r;
	logic internal_return_path_r;
	logic slave_output_disable_r;
	logic role_select_r;
	logic format_r;
	logic auto_select_disable_r;
	logic flush_r;
	logic [3:0] frame_length_code_r;
	logic [2:0] rx_fill_threshold_r;
	logic [2:0] tx_fill_threshold_r;
	logic cpha_r;
	logic cpol_r;
	logic bit_order_select_r;
	logic [7:0] div_r;

	// Bus slave
	logic wr_pend_r;
	logic rd_pend_r;
	logic rd_done_r;
	logic [7:0] addr_r;
	logic [31:0] rdata_r;

	// FIFOs
	logic [2:0] tx_wp_r;
	logic [2:0] tx_rp_r;
	logic [3:0] tx_cnt_r;
	logic [2:0] rx_wp_r;
	logic [2:0] rx_rp_r;
	logic [3:0] rx_cnt_r;
	logic [15:0] tx_q;
	logic [15:0] rx_q;

	// Engine
	eng_state_t state_r;
	logic [7:0] div_cnt_r;
	logic [4:0] edge_cnt_r;
	logic sck_r;
	logic sel_r;
	logic out_r;
	logic sck_q_r;
	logic [15:0] tx_word_r;
	logic [15:0] rx_word_r;
	logic [3:0] tx_idx_r;
	logic [3:0] rx_idx_r;

	// ==========================================================
	// Bus decode

	wire a_phase = hsel & htrans[1] & hready;
	wire rd_cap = rd_pend_r & ~rd_done_r;
	wire wr_main = wr_pend_r & (addr_r == OFS_MAIN);
	wire wr_shape = wr_pend_r & (addr_r == OFS_SHAPE);
	wire wr_div = wr_pend_r & (addr_r == OFS_DIV);
	wire wr_data = wr_pend_r & (addr_r == OFS_DATA);
	wire rd_data = rd_cap & (addr_r == OFS_DATA);

	// ==========================================================
	// Role and FIFO state

	// Only the four-wire format runs; the reserved code keeps the port quiet
	wire active = port_enable_r & ~format_r;
	wire master = active & ~role_select_r;
	wire slave = active & role_select_r;
	wire tx_empty = (tx_cnt_r == 4'h0);
	wire tx_full = (tx_cnt_r == FIFO_DEPTH);
	wire rx_empty = (rx_cnt_r == 4'h0);
	wire rx_full = (rx_cnt_r == FIFO_DEPTH);
	wire tx_thf = (tx_cnt_r <= {1'b0, tx_fill_threshold_r});
	wire rx_thf = (rx_cnt_r > {1'b0, rx_fill_threshold_r});
	wire busy = (state_r != ST_IDLE);

	// ==========================================================
	// Read mux

	// Flush field is write-only and always reads zero
	wire [31:0] main_rd = {13'h0, auto_select_disable_r, rx_fill_threshold_r, tx_fill_threshold_r,
		frame_length_code_r, 2'b00, 1'b0, format_r, role_select_r, slave_output_disable_r,
		internal_return_path_r, port_enable_r};
	wire [31:0] stat_rd = {25'h0, rx_thf, tx_thf, busy, rx_full, rx_empty, tx_full, tx_empty};
	wire [31:0] rd_mux = (addr_r == OFS_MAIN) ? main_rd :
		(addr_r == OFS_SHAPE) ? {29'h0, cpha_r, cpol_r, bit_order_select_r} :
		(addr_r == OFS_DIV) ? {24'h0, div_r} :
		(addr_r == OFS_STAT) ? stat_rd :
		(addr_r == OFS_DATA) ? {16'h0, rx_empty ? 16'h0 : rx_q} : 32'h0;

	// ==========================================================
	// Engine events

	wire m_tick = (div_cnt_r == div_r);
	wire m_edge = master & (state_r == ST_SHIFT) & m_tick;
	wire m_lead = m_edge & (sck_r == cpol_r);
	wire m_trail = m_edge & (sck_r != cpol_r);
	// Slave sees only the outside clock, and only while selected
	wire s_edge = slave & (state_r == ST_SHIFT) & (sck_in != sck_q_r) & ~slave_select_pin_in;
	wire s_lead = s_edge & (sck_in != cpol_r);
	wire s_trail = s_edge & (sck_in == cpol_r);
	wire lead = m_lead | s_lead;
	wire trail = m_trail | s_trail;
	wire cap = cpha_r ? trail : lead;
	wire shf = cpha_r ? lead : trail;
	wire in_bit = internal_return_path_r ? out_r : (role_select_r ? mosi_in : miso_in);
	wire [3:0] rx_pos = bit_pos(rx_idx_r, frame_length_code_r, bit_order_select_r);
	wire [3:0] tx_pos = bit_pos(tx_idx_r, frame_length_code_r, bit_order_select_r);
	wire [15:0] rx_fill = rx_word_r | (16'(in_bit) << rx_pos);
	wire done = cap & (rx_idx_r == frame_length_code_r);
	wire m_last = m_edge & (edge_cnt_r == {frame_length_code_r, 1'b1});
	// A full receive FIFO drops the new frame
	wire rx_push = done & ~rx_full;
	wire rx_pop = rd_data & ~rx_empty;
	wire tx_push = wr_data & ~tx_full;
	wire slave_start = slave & ~slave_select_pin_in & ((state_r == ST_IDLE) | done);
	wire frame_start = ((state_r == ST_LOAD) & master) | slave_start;
	wire tx_pop = frame_start & ~tx_empty;
	// Empty FIFO at a slave frame sends zeros
	wire [15:0] start_word = tx_empty ? 16'h0 : tx_q;
	wire [3:0] first_pos = bit_pos(4'h0, frame_length_code_r, bit_order_select_r);

	// ==========================================================
	// AHB-Lite slave: writes take no wait, reads one wait state

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			rd_done_r <= 1'b0;
			addr_r <= 8'h00;
			rdata_r <= 32'h0;
		end else begin
			if (a_phase) begin
				wr_pend_r <= hwrite;
				rd_pend_r <= ~hwrite;
				addr_r <= haddr[7:0];
			end else if (hreadyout) begin
				wr_pend_r <= 1'b0;
				rd_pend_r <= 1'b0;
			end
			rd_done_r <= rd_cap;
			if (rd_cap) begin
				rdata_r <= rd_mux;
			end
		end
	end

	assign hreadyout = ~rd_cap;
	assign hrdata = rdata_r;
	assign hresp = 1'b0;

	// ==========================================================
	// Configuration registers

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			auto_select_disable_r <= RST_SEL_OFF;
			rx_fill_threshold_r <= RST_TH;
			tx_fill_threshold_r <= RST_TH;
			frame_length_code_r <= RST_LEN;
			format_r <= 1'b0;
			role_select_r <= 1'b0;
			slave_output_disable_r <= 1'b0;
			internal_return_path_r <= 1'b0;
			port_enable_r <= 1'b0;
		end else if (wr_main) begin
			auto_select_disable_r <= hwdata[POS_SEL_OFF];
			rx_fill_threshold_r <= hwdata[POS_RXTH +: 3];
			tx_fill_threshold_r <= hwdata[POS_TXTH +: 3];
			frame_length_code_r <= hwdata[POS_LEN +: 4];
			format_r <= hwdata[POS_FORMAT];
			role_select_r <= hwdata[POS_ROLE];
			slave_output_disable_r <= hwdata[POS_MISO_OFF];
			internal_return_path_r <= hwdata[POS_LOOP];
			port_enable_r <= hwdata[POS_EN];
		end
	end

	// Flush lasts one cycle and clears itself; other codes do nothing
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			flush_r <= 1'b0;
		end else begin
			flush_r <= wr_main & (hwdata[POS_FLUSH +: 2] == FLUSH_GO);
		end
	end

	// Clock shape and divisor
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cpha_r <= 1'b0;
			cpol_r <= 1'b0;
			bit_order_select_r <= 1'b0;
			div_r <= RST_DIV;
		end else begin
			if (wr_shape) begin
				cpha_r <= hwdata[POS_CPHA];
				cpol_r <= hwdata[POS_CPOL];
				bit_order_select_r <= hwdata[POS_ORDER];
			end
			if (wr_div) begin
				div_r <= hwdata[7:0];
			end
		end
	end

	// ==========================================================
	// FIFO pointers; flush empties both

	always_ff @(posedge clock) begin
		if (!rst_b || flush_r) begin
			tx_wp_r <= 3'h0;
			tx_rp_r <= 3'h0;
			tx_cnt_r <= 4'h0;
			rx_wp_r <= 3'h0;
			rx_rp_r <= 3'h0;
			rx_cnt_r <= 4'h0;
		end else begin
			tx_wp_r <= tx_wp_r + {2'b00, tx_push};
			tx_rp_r <= tx_rp_r + {2'b00, tx_pop};
			tx_cnt_r <= tx_cnt_r + {3'h0, tx_push} - {3'h0, tx_pop};
			rx_wp_r <= rx_wp_r + {2'b00, rx_push};
			rx_rp_r <= rx_rp_r + {2'b00, rx_pop};
			rx_cnt_r <= rx_cnt_r + {3'h0, rx_push} - {3'h0, rx_pop};
		end
	end

	// Transmit and receive frame stores
	spi_word_mem tx_mem (
		.clock(clock),
		.wr_en(tx_push),
		.wr_addr(tx_wp_r),
		.wr_data(hwdata[15:0]),
		.rd_addr(tx_rp_r),
		.rd_data(tx_q)
	);

	spi_word_mem rx_mem (
		.clock(clock),
		.wr_en(rx_push),
		.wr_addr(rx_wp_r),
		.wr_data(rx_fill),
		.rd_addr(rx_rp_r),
		.rd_data(rx_q)
	);

	// ==========================================================
	// Engine state machine

	// Dropping enable or a flush aborts any frame in flight
	always_ff @(posedge clock) begin
		if (!rst_b || flush_r || !active) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (master && !tx_empty) begin
						state_r <= ST_LOAD;
					end else if (slave_start) begin
						state_r <= ST_SHIFT;
					end
				end
				ST_LOAD: begin
					state_r <= master ? ST_SHIFT : ST_IDLE;
				end
				ST_SHIFT: begin
					if (m_last) begin
						state_r <= ST_TAIL;
					end else if (slave && slave_select_pin_in) begin
						state_r <= ST_IDLE;
					end
				end
				ST_TAIL: begin
					if (m_tick) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Master clock generation: half period is divisor plus one

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			div_cnt_r <= 8'h00;
			edge_cnt_r <= 5'h00;
			sck_r <= 1'b0;
			sel_r <= 1'b1;
		end else begin
			if ((state_r == ST_SHIFT || state_r == ST_TAIL) && !m_tick) begin
				div_cnt_r <= div_cnt_r + 8'h01;
			end else begin
				div_cnt_r <= 8'h00;
			end
			if (state_r != ST_SHIFT) begin
				edge_cnt_r <= 5'h00;
				sck_r <= cpol_r;
			end else if (m_edge) begin
				edge_cnt_r <= edge_cnt_r + 5'h01;
				sck_r <= ~sck_r;
			end
			// Select low from load until the tail half period ends
			sel_r <= ~(master && (state_r == ST_LOAD || state_r == ST_SHIFT || state_r == ST_TAIL));
		end
	end

	// ==========================================================
	// Shift datapath

	// Start of frame overrides the bit steps of the same cycle
	always_ff @(posedge clock) begin
		if (!rst_b || flush_r) begin
			tx_word_r <= 16'h0;
			rx_word_r <= 16'h0;
			tx_idx_r <= 4'h0;
			rx_idx_r <= 4'h0;
			out_r <= 1'b0;
		end else if (frame_start) begin
			tx_word_r <= start_word;
			rx_word_r <= 16'h0;
			rx_idx_r <= 4'h0;
			// Phase 0 puts the first bit out before the first edge
			if (!cpha_r) begin
				out_r <= start_word[first_pos];
				tx_idx_r <= 4'h1;
			end else begin
				tx_idx_r <= 4'h0;
			end
		end else begin
			if (cap) begin
				rx_word_r <= rx_fill;
				rx_idx_r <= rx_idx_r + 4'h1;
			end
			// A shift past the last bit, due on the last edge, is blocked by the index limit, except in 16-bit frames where the index wraps to 0
			if (shf && tx_idx_r <= frame_length_code_r) begin
				out_r <= tx_word_r[tx_pos];
				tx_idx_r <= tx_idx_r + 4'h1;
			end
		end
	end

	// Edge detect reference for the outside clock
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sck_q_r <= 1'b0;
		end else begin
			sck_q_r <= sck_in;
		end
	end

	// ==========================================================
	// Pins: enables low while driving, switched by role; the select pin also needs auto-select on

	assign sck_out = sck_r;
	assign sck_oe_b = ~master;
	assign mosi_out = out_r;
	assign mosi_oe_b = ~master;
	assign miso_out = slave_output_disable_r ? 1'b0 : out_r;
	assign miso_oe_b = ~slave;
	assign slave_select_pin_out = sel_r;
	// Disabled auto-select leaves the pin to general purpose use
	assign slave_select_pin_oe_b = ~(master & ~auto_select_disable_r);

endmodule

// file: spi_cfg_pkg.sv
// Register map, field layout, reset values and engine states of the serial port
package spi_cfg_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_MAIN = 8'h00;
	localparam logic [7:0] OFS_SHAPE = 8'h04;
	localparam logic [7:0] OFS_DIV = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [7:0] OFS_DATA = 8'h1c;

	// ==========================================================
	// Field positions in serial_control_main
	localparam int POS_SEL_OFF = 18;
	localparam int POS_RXTH = 15;
	localparam int POS_TXTH = 12;
	localparam int POS_LEN = 8;
	localparam int POS_FLUSH = 6;
	localparam int POS_FORMAT = 4;
	localparam int POS_ROLE = 3;
	localparam int POS_MISO_OFF = 2;
	localparam int POS_LOOP = 1;
	localparam int POS_EN = 0;

	// Field positions in serial_clock_shape
	localparam int POS_CPHA = 2;
	localparam int POS_CPOL = 1;
	localparam int POS_ORDER = 0;

	// ==========================================================
	// Reset values and codes
	localparam logic RST_SEL_OFF = 1'b1;
	localparam logic [2:0] RST_TH = 3'h0;
	localparam logic [3:0] RST_LEN = 4'hf;
	localparam logic [7:0] RST_DIV = 8'h00;
	localparam logic [1:0] FLUSH_GO = 2'h3;
	localparam logic [3:0] FIFO_DEPTH = 4'h8;

	// ==========================================================
	// Serial engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOAD = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_TAIL = 4'b1000
	} eng_state_t;

endpackage

// file: spi_word_mem.sv
// Eight-word frame store with registered read data and write bypass
`timescale 1ns/1ps
module spi_word_mem (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [2:0] rd_addr,
	output logic [15:0] rd_data
);
	logic [15:0] mem [0:7];

	// ==========================================================
	// Storage write
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Bypass so a word written this cycle is seen at once
	always_ff @(posedge clock) begin
		rd_data <= (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
	end
endmodule

// file: spi_cfg_monitor.sv
// Port checker for the serial port controller
`timescale 1ns/1ps
module spi_cfg_monitor (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic sck_out,
	input wire logic sck_oe_b,
	input wire logic slave_select_pin_out,
	input wire logic slave_select_pin_oe_b,
	input wire logic mosi_oe_b,
	input wire logic miso_out,
	input wire logic miso_oe_b
);
	import spi_cfg_pkg::*;
	// =====
	// Shadow of the control fields, rebuilt from bus writes
	logic wr_r;
	logic sck_r;
	logic tog_r;
	logic [7:0] ad_r;
	logic [7:0] div_r;
	logic [8:0] cnt_r;
	logic [2:0] shp_r;
	logic [31:0] main_r;
	wire take = hsel && htrans[1] && hready;
	wire mst_on = main_r[POS_EN] && !main_r[POS_FORMAT] && !main_r[POS_ROLE];
	wire sl = main_r[POS_EN] && !main_r[POS_FORMAT] && main_r[POS_ROLE];
	wire sdo_off = sl && main_r[POS_MISO_OFF];
	wire chg = sck_out != sck_r;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_r <= 1'b0;
			main_r <= 32'h0004_0f00;
			shp_r <= 3'h0;
			div_r <= RST_DIV;
		end else begin
			wr_r <= take && hwrite;
			main_r <= (wr_r && ad_r == OFS_MAIN) ? (hwdata & 32'h0007_ff1f) : main_r;
			shp_r <= (wr_r && ad_r == OFS_SHAPE) ? hwdata[2:0] : shp_r;
			div_r <= (wr_r && ad_r == OFS_DIV) ? hwdata[7:0] : div_r;
		end
	end
	// Clocks since the last serial clock change; free running, no reset needed
	always_ff @(posedge clock) begin
		ad_r <= haddr[7:0];
		sck_r <= sck_out;
		cnt_r <= chg ? 9'h0 : cnt_r + 9'h1;
		tog_r <= !slave_select_pin_out && (tog_r || chg);
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// =====
	// Bus and pin behaviour
	property p_rd_wait;
		take && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_sck_dir;
		$stable(main_r) |-> sck_oe_b == !mst_on;
	endproperty
	a_sck_dir: assert property (p_sck_dir) else $error("clock direction wrong");
	property p_mosi_dir;
		$stable(main_r) |-> mosi_oe_b == !mst_on;
	endproperty
	a_mosi_dir: assert property (p_mosi_dir) else $error("data out direction wrong");
	property p_miso_dir;
		$stable(main_r) |-> miso_oe_b == !sl;
	endproperty
	a_miso_dir: assert property (p_miso_dir) else $error("slave data direction wrong");
	property p_sel_dir;
		$stable(main_r) |-> slave_select_pin_oe_b == !(mst_on && !main_r[POS_SEL_OFF]);
	endproperty
	a_sel_dir: assert property (p_sel_dir) else $error("select direction wrong");
	property p_sdo_off;
		sdo_off && $past(sdo_off) |-> !miso_out;
	endproperty
	a_sdo_off: assert property (p_sdo_off) else $error("slave data not held low");
	property p_idle;
		slave_select_pin_out && $past(slave_select_pin_out) && mst_on && $stable(main_r) && $stable(shp_r)
			|-> sck_out == shp_r[POS_CPOL];
	endproperty
	a_idle: assert property (p_idle) else $error("clock idle level wrong");
	property p_half;
		mst_on && !slave_select_pin_out && tog_r && chg |-> cnt_r == {1'b0, div_r};
	endproperty
	a_half: assert property (p_half) else $error("half period wrong");
endmodule

// file: spi_peer_slave.sv
// Behavioural serial slave facing the controller in master role
`timescale 1ns/1ps
module spi_peer_slave (
	input wire logic sck,
	input wire logic sel_b,
	input wire logic mosi,
	input wire logic cpha,
	input wire logic lsb,
	input wire logic [4:0] len,
	input wire logic [15:0] word,
	output logic miso,
	output logic [15:0] got,
	output int frames
);
	int e;
	int k;
	// Bit for slot i; past the frame the line shows its inverse
	function automatic logic pick(input int i);
		if (i >= len) return ~miso;
		return lsb ? word[i] : word[len - 1 - i];
	endfunction
	initial begin
		miso = 1'b0;
		got = 16'h0;
		frames = 0;
	end
	// With phase 0 the first bit must stand before any clock edge
	always @(negedge sel_b) begin
		e = 0;
		k = 0;
		got = 16'h0;
		if (!cpha) miso = pick(0);
	end
	// Released line: inverse of last value, so stale data never matches
	always @(posedge sel_b) begin
		miso = ~miso;
	end
	// Edges alternate capture and shift; phase picks which comes first
	always @(sck) begin
		if (!sel_b) begin
			if (e[0] == cpha) begin
				if (lsb) got[k] = mosi;
				else got = {got[14:0], mosi};
				k++;
				if (k == len) frames++;
			end else begin
				miso = pick(k);
			end
			e++;
		end
	end
endmodule

// file: tb_top.sv
// Self-checking bench for the serial port controller
`timescale 1ns/1ps
module tb_top;
	import spi_cfg_pkg::*;
	logic clock, rst_b, hsel, hwrite, hreadyout, hresp, sck_in, sel_drv, mosi_in;
	logic sck_out, sck_oe_b, sel_out, sel_oe_b, mosi_out, mosi_oe_b, miso_out, miso_oe_b, peer_miso;
	logic [31:0] haddr, hwdata, hrdata, q, v, w, msk;
	logic [1:0] htrans;
	logic [15:0] peer_word, peer_got, r;
	logic [4:0] len;
	logic [2:0] shp;
	logic [15:0] tx_q[$];
	int frames, errors, n_checks, f;
	wire sel_w = sel_oe_b ? sel_drv : sel_out;
	wire sck_w = sck_oe_b ? 1'b0 : sck_out;
	spi_controller_config_core spi_controller_config_core_i (.clock(clock), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sck_in(sck_in), .sck_out(sck_out),
		.sck_oe_b(sck_oe_b), .slave_select_pin_in(sel_w), .slave_select_pin_out(sel_out),
		.slave_select_pin_oe_b(sel_oe_b), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_b(mosi_oe_b),
		.miso_in(peer_miso), .miso_out(miso_out), .miso_oe_b(miso_oe_b));
	spi_peer_slave spi_peer_slave_i (.sck(sck_w), .sel_b(sel_w), .mosi(mosi_out), .cpha(shp[2]), .lsb(shp[0]),
		.len(len), .word(peer_word), .miso(peer_miso), .got(peer_got), .frames(frames));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// =====
	// Reporting and bus tasks
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Bounded wait for ready; a hang ends the run
	task automatic rdy();
		int n;
		n = 0;
		@(posedge clock);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				chk(0, 1);
				stop_test();
			end
			@(posedge clock);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		q = hrdata;
		// The one slave never answers with an error
		chk(hresp, 0);
	endtask
	// Waits out one frame at the peer, then the select release
	task automatic frame(input logic [15:0] e);
		int n;
		f = frames;
		for (n = 0; frames == f && n < 3000; n++) @(posedge clock);
		// A frame that never ends is a hang: count it and close the run
		if (n >= 3000) begin
			chk(0, 1);
			stop_test();
		end
		chk(peer_got, e);
		for (n = 0; sel_w !== 1'b1 && n < 300; n++) @(posedge clock);
		if (n >= 300) begin
			chk(0, 1);
			stop_test();
		end
	endtask
	// =====
	// Scenarios
	initial begin
		{rst_b, hsel, hwrite, sck_in, mosi_in, htrans, haddr, hwdata, peer_word} = '0;
		{sel_drv, len, shp} = {1'b1, 5'd16, 3'h0};
		{errors, n_checks} = 0;
		q = $urandom(32'h534ca4b8);
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		bus(0, OFS_MAIN, 0);
		chk(q, 32'h0004_0f00);
		bus(0, OFS_SHAPE, 0);
		chk(q, 0);
		bus(0, OFS_STAT, 0);
		chk(q, 32'h25);
		bus(0, 8'h40, 0);
		chk(q, 0);
		for (int i = 0; i < 4; i++) begin
			v = $urandom & 32'h0007_ff0e;
			bus(1, OFS_MAIN, v | 32'hc0);
			bus(0, OFS_MAIN, 0);
			chk(q, v);
			v = $urandom;
			bus(1, OFS_SHAPE, v);
			bus(0, OFS_SHAPE, 0);
			chk(q, v & 32'h7);
			bus(1, OFS_DIV, v);
			bus(0, OFS_DIV, 0);
			chk(q, v & 32'hff);
		end
		$display("registers done");
		// Every phase, polarity and order, two frames back to back
		for (int m = 0; m < 8; m++) begin
			len <= 5'($urandom_range(16, 3));
			// Settings change only with the port off, so no flush is owed
			bus(1, OFS_MAIN, 0);
			msk = (32'h1 << len) - 1;
			shp <= 3'(m);
			bus(1, OFS_SHAPE, m);
			bus(1, OFS_DIV, $urandom_range(2));
			peer_word <= 16'($urandom);
			repeat (2) begin
				v = $urandom & msk;
				tx_q.push_back(v[15:0]);
				bus(1, OFS_DATA, v);
			end
			bus(1, OFS_MAIN, ((len - 1) << 8) | 1);
			repeat (2) frame(tx_q.pop_front());
			repeat (2) begin
				bus(0, OFS_DATA, 0);
				chk(q, peer_word & msk);
			end
		end
		$display("master frames done");
		bus(1, OFS_MAIN, 0);
		bus(1, OFS_SHAPE, 0);
		{shp, len} = {3'h0, 5'd16};
		v = $urandom & 32'hffff;
		peer_word <= ~v[15:0];
		bus(1, OFS_DATA, v);
		bus(1, OFS_MAIN, 32'h0f03);
		frame(v[15:0]);
		bus(0, OFS_DATA, 0);
		chk(q, v);
		bus(1, OFS_MAIN, 0);
		repeat (3) bus(1, OFS_DATA, $urandom);
		// Reserved format with enable set keeps the engine quiet; threshold 3
		f = frames;
		bus(1, OFS_MAIN, 32'h3f11);
		repeat (100) @(posedge clock);
		chk(frames, f);
		bus(0, OFS_STAT, 0);
		chk(q, 32'h24);
		bus(1, OFS_MAIN, 32'hc0);
		bus(0, OFS_STAT, 0);
		chk(q, 32'h25);
		bus(0, OFS_MAIN, 0);
		chk(q, 0);
		f = frames;
		bus(1, OFS_MAIN, 32'h0f01);
		repeat (300) @(posedge clock);
		chk(frames, f);
		$display("internal_return_path and flush done");
		// Slave role: bench is the far master, divisor set high to be ignored
		bus(1, OFS_MAIN, 0);
		bus(1, OFS_DIV, 32'hff);
		{v, w} = {$urandom & 32'hffff, $urandom & 32'hffff};
		bus(1, OFS_DATA, v);
		bus(1, OFS_MAIN, 32'h0f09);
		sel_drv <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_in <= w[i];
			repeat (4) @(posedge clock);
			r[i] = miso_out;
			sck_in <= 1'b1;
			repeat (4) @(posedge clock);
			sck_in <= 1'b0;
		end
		repeat (4) @(posedge clock);
		sel_drv <= 1'b1;
		mosi_in <= ~w[0];
		chk(r, v);
		bus(0, OFS_DATA, 0);
		chk(q, w);
		// All ones loaded, so a line held low cannot pass by chance
		bus(1, OFS_MAIN, 0);
		bus(1, OFS_DATA, 32'hffff);
		bus(1, OFS_MAIN, 32'h0f0d);
		sel_drv <= 1'b0;
		repeat (4) @(posedge clock);
		chk(miso_out, 0);
		sel_drv <= 1'b1;
		bus(1, OFS_MAIN, 0);
		bus(1, OFS_MAIN, 32'h0f09);
		repeat (2) @(posedge clock);
		chk(miso_out, 1);
		$display("slave done");
		stop_test();
	end
endmodule
bind spi_controller_config_core spi_cfg_monitor spi_cfg_monitor_i (.clock(clock), .rst_b(rst_b), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.sck_out(sck_out), .sck_oe_b(sck_oe_b), .slave_select_pin_out(slave_select_pin_out),
	.slave_select_pin_oe_b(slave_select_pin_oe_b), .mosi_oe_b(mosi_oe_b), .miso_out(miso_out),
	.miso_oe_b(miso_oe_b));
